// >>> common/ttc_cfg.svh
/*
  Offsets, field positions, reset values and identification addresses of the
  test and configuration register bank.
  Assumes a 16-bit register port addressed by byte offset from the board base.
*/
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TTC_OFS_MODE_SET 16'h1032
`define TTC_OFS_MODE_BIT_CLEAR 16'h1034
`define TTC_OFS_TEST_WRITE_ADDRESS 16'h1036
`define TTC_OFS_TEST_PATTERN_UPPER 16'h1038
`define TTC_OFS_TEST_PATTERN_LOWER 16'h103A
`define TTC_OFS_CRATE_NUMBER 16'h103C
`define TTC_OFS_TEST_EVENT_FIFO_WRITE 16'h103E
`define TTC_OFS_EVENT_COUNT_CLEAR 16'h1040
`define TTC_OFS_RANGE_SETTING 16'h1060
`define TTC_OFS_TEST_READ_ADDRESS 16'h1064
`define TTC_OFS_SOFT_CONVERSION_TRIGGER 16'h1068
`define TTC_OFS_SLIDE_FIXED_VALUE 16'h106A
`define TTC_OFS_BLOCK_A_RESULT 16'h1070
`define TTC_OFS_BLOCK_B_RESULT 16'h1072
`define TTC_OFS_THRESHOLD_FIRST 16'h1080
`define TTC_OFS_THRESHOLD_LAST 16'h10BE
`define TTC_OFS_ROM_FIRST 16'h8000

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define TTC_MODE_MEM_TEST 0
`define TTC_MODE_DATA_CLEAR 2
`define TTC_MODE_ACQ_TEST 6
`define TTC_MODE_SLIDE_ON 7
`define TTC_MODE_THRESHOLD_STEP_SELECT 8
`define TTC_MODE_RESET 16'h4080

// ----------------------------------------
// Field widths and layouts
// ----------------------------------------
`define TTC_ADDR_W 11
`define TTC_BYTE_W 8
`define TTC_VALUE_W 12
`define TTC_OVERFLOW_BIT 12
`define TTC_KILL_BIT 8
`define TTC_CH32_SHIFT 1
`define TTC_CH16_SHIFT 2
`define TTC_SCALE_COARSE 4
`define TTC_SCALE_FINE 1

// ----------------------------------------
// Identification table addresses
// ----------------------------------------
`define TTC_ROM_OUI_MSB 16'h8026
`define TTC_ROM_OUI 16'h802A
`define TTC_ROM_OUI_LSB 16'h802E
`define TTC_ROM_VERSION 16'h8032
`define TTC_ROM_BOARD_MSB 16'h8036
`define TTC_ROM_BOARD 16'h803A
`define TTC_ROM_BOARD_LSB 16'h803E
`define TTC_ROM_REVISION 16'h804E
`define TTC_ROM_SERIAL_MSB 16'h8F02
`define TTC_ROM_SERIAL_LSB 16'h8F06

`endif

// >>> common/ttc_pkg.sv
/*
  Types shared by the test and configuration register bank.
  Assumes ttc_cfg.svh is compiled on the include path.
*/
package ttc_pkg;

  // Host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ttc_reg_req_t;

  // Word committed into the output buffer by a memory test
  typedef struct packed {
    logic valid;
    logic [10:0] addr;
    logic [31:0] data;
  } ttc_mem_write_t;

  // Test event word handed to the output buffer path
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } ttc_event_word_t;

  // Per-channel acceptance query from the conversion path
  typedef struct packed {
    logic valid;
    logic [4:0] channel;
    logic [11:0] value;
    logic overflow;
  } ttc_check_t;

endpackage : ttc_pkg

// >>> rtl/ttc_event_fifo.sv
/*
  Circular store of test event words, pushed by host writes and drained
  word by word in acquisition test mode.
  Assumes one clock and synchronous reset; overwrite on overflow is intended.
*/
`timescale 1ns/1ps
`include "ttc_cfg.svh"

module ttc_event_fifo #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_word_i,
  input wire logic clear_write_i,
  input wire logic clear_read_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] pop_word_o
);
  import ttc_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [WIDTH-1:0] out;
  } ttc_fifo_state_t;

  ttc_fifo_state_t state;
  ttc_fifo_state_t next_state;
  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------
  // Pointer logic
  // ----------------------------------------
  // Pointers wrap freely so a 33rd write overwrites the oldest word
  always_comb begin
    next_state = state;
    if (clear_write_i) begin
      next_state.wptr = '0;
    end else if (push_i) begin
      next_state.wptr = state.wptr + 1'b1;
    end
    if (clear_read_i) begin
      next_state.rptr = '0;
    end else if (pop_i) begin
      next_state.rptr = state.rptr + 1'b1;
      next_state.out = mem[state.rptr];
    end
  end

  // Storage has no reset: unwritten entries are undefined by design
  always_ff @(posedge ref_clk_i) begin
    if (push_i) begin
      mem[state.wptr] <= push_word_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pop_word_o = state.out;

endmodule : ttc_event_fifo

// >>> rtl/ttc_test_config_regs.sv
/*
  Upper part of the converter register bank: mode bits, memory test access,
  test event loading, crate number, counters, range, slide constant, ADC
  readback, per-channel thresholds and the identification table.
  Assumes a host port with one-cycle read/write strobes, synchronous to
  ref_clk_i; read data appears one cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "ttc_cfg.svh"

// Function
// - Bit-clear write clears mode bits written one
// - Separate 11-bit test write and read addresses
// - Upper half held; lower write commits word
// - Crate number readable, writable, sent in headers
// - Test event writes fill 32-word FIFO
// - Test word: 12-bit value plus overflow flag
// - Exactly 32 words; extra writes overwrite
// - Any write clears the event counter
// - Eight-bit range value sets time step
// - Any write starts one test conversion
// - Eight-bit slide constant drives DAC when disabled
// - Readback of latest block A and B results
// - Threshold table address map per variant
// - Suppress bit set means channel never stored
// - Threshold compared to upper eight value bits with step select clear
// - Thresholds reset only by hardware reset
// - Identification table at fixed read-only addresses
// - Step select scales threshold by 16 or 2
// - Slide disabled drives DAC with constant
module ttc_test_config_regs #(
  parameter int CHANNELS = 32,
  parameter int FIFO_DEPTH = 32,
  parameter logic [7:0] OUI_MSB_VALUE = 8'h5A, // arbitrary
  parameter logic [7:0] OUI_MID_VALUE = 8'h5B, // arbitrary
  parameter logic [7:0] OUI_LSB_VALUE = 8'h5C, // arbitrary
  parameter logic [7:0] VERSION_VALUE = 8'h21, // arbitrary
  parameter logic [7:0] BOARD_MSB_VALUE = 8'h31, // arbitrary
  parameter logic [7:0] BOARD_MID_VALUE = 8'h32, // arbitrary
  parameter logic [7:0] BOARD_LSB_VALUE = 8'h33, // arbitrary
  parameter logic [7:0] REVISION_VALUE = 8'h41, // arbitrary
  parameter logic [7:0] SERIAL_MSB_VALUE = 8'h51, // arbitrary
  parameter logic [7:0] SERIAL_LSB_VALUE = 8'h52 // arbitrary
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  input wire ttc_pkg::ttc_reg_req_t req_i,
  input wire logic event_count_inc_i,
  input wire logic [11:0] block_a_value_i,
  input wire logic block_a_valid_i,
  input wire logic [11:0] block_b_value_i,
  input wire logic block_b_valid_i,
  input wire ttc_pkg::ttc_check_t check_i,
  input wire logic test_event_pop_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic [15:0] mode_o,
  output ttc_pkg::ttc_mem_write_t mem_write_o,
  output logic [10:0] test_read_address_o,
  output logic [15:0] crate_number_o,
  output logic [23:0] event_count_o,
  output logic [7:0] range_setting_o,
  output logic conversion_start_o,
  output logic [7:0] slide_dac_o,
  output logic check_valid_o,
  output logic check_accept_o,
  output ttc_pkg::ttc_event_word_t test_event_o
);
  import ttc_pkg::*;

  typedef struct packed {
    logic [15:0] mode;
    logic [10:0] waddr;
    logic [10:0] raddr;
    logic [15:0] upper;
    ttc_mem_write_t mem_write;
    logic [15:0] crate;
    logic [23:0] evcount;
    logic [7:0] range;
    logic conv;
    logic [7:0] slide_const;
    logic [7:0] slide_dac;
    logic [7:0] slide_ramp;
    logic [11:0] block_a;
    logic [11:0] block_b;
    logic [15:0] rdata;
    logic rvalid;
    logic chk_valid;
    logic chk_accept;
    logic pop_d;
  } ttc_state_t;

  ttc_state_t state;
  ttc_state_t next_state;

  // Threshold table: kill bit plus 8-bit threshold per channel
  logic [8:0] thr_mem [CHANNELS];
  logic [15:0] fifo_word;
  logic acq_rise;
  logic acq_fall;
  logic fifo_push;
  logic thr_hit;
  logic [4:0] thr_index;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Threshold slot decode; stride depends on the channel count variant
  function automatic logic [5:0] thr_decode(input logic [15:0] addr);
    logic [15:0] rel;
    logic hit;
    logic [4:0] index;
    rel = addr - `TTC_OFS_THRESHOLD_FIRST;
    hit = 1'b0;
    index = '0;
    if (addr >= `TTC_OFS_THRESHOLD_FIRST && addr <= `TTC_OFS_THRESHOLD_LAST) begin
      if (CHANNELS > 16) begin
        hit = (rel[0] == 1'b0);
        index = rel[5:1];
      end else begin
        hit = (rel[1:0] == 2'b00);
        index = {1'b0, rel[5:2]};
      end
    end
    return {hit, index};
  endfunction : thr_decode

  // Identification table lookup, zero elsewhere in the region
  function automatic logic [7:0] rom_byte(input logic [15:0] addr);
    unique case (addr)
      `TTC_ROM_OUI_MSB: return OUI_MSB_VALUE;
      `TTC_ROM_OUI: return OUI_MID_VALUE;
      `TTC_ROM_OUI_LSB: return OUI_LSB_VALUE;
      `TTC_ROM_VERSION: return VERSION_VALUE;
      `TTC_ROM_BOARD_MSB: return BOARD_MSB_VALUE;
      `TTC_ROM_BOARD: return BOARD_MID_VALUE;
      `TTC_ROM_BOARD_LSB: return BOARD_LSB_VALUE;
      `TTC_ROM_REVISION: return REVISION_VALUE;
      `TTC_ROM_SERIAL_MSB: return SERIAL_MSB_VALUE;
      `TTC_ROM_SERIAL_LSB: return SERIAL_LSB_VALUE;
      default: return 8'h00;
    endcase
  endfunction : rom_byte

  function automatic logic is_write(input ttc_reg_req_t r, input logic [15:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction : is_write

  assign {thr_hit, thr_index} = thr_decode(req_i.addr);

  // ----------------------------------------
  // Test event store
  // ----------------------------------------
  // Raising the test bit rewinds the write side, dropping it rewinds reads
  assign acq_rise = next_state.mode[`TTC_MODE_ACQ_TEST] && !state.mode[`TTC_MODE_ACQ_TEST];
  assign acq_fall = !next_state.mode[`TTC_MODE_ACQ_TEST] && state.mode[`TTC_MODE_ACQ_TEST];
  assign fifo_push = is_write(req_i, `TTC_OFS_TEST_EVENT_FIFO_WRITE);

  ttc_event_fifo #(
    .DEPTH(FIFO_DEPTH),
    .WIDTH(16)
  ) u_event_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .push_i(fifo_push),
    .push_word_i(req_i.wdata),
    .clear_write_i(acq_rise),
    .clear_read_i(acq_fall),
    .pop_i(test_event_pop_i && state.mode[`TTC_MODE_ACQ_TEST]),
    .pop_word_o(fifo_word)
  );

  // ----------------------------------------
  // Register writes and derived state
  // ----------------------------------------
  always_comb begin
    logic [8:0] entry;
    logic [12:0] limit;
    next_state = state;
    entry = thr_mem[check_i.channel];
    limit = '0;
    next_state.mem_write.valid = 1'b0;
    next_state.conv = 1'b0;
    next_state.rvalid = 1'b0;
    next_state.chk_valid = 1'b0;
    next_state.pop_d = test_event_pop_i && state.mode[`TTC_MODE_ACQ_TEST];
    // Mode set and clear share one layout
    if (is_write(req_i, `TTC_OFS_MODE_SET)) begin
      next_state.mode = state.mode | req_i.wdata;
    end

    // Ones clear their bit, zeros leave it
    if (is_write(req_i, `TTC_OFS_MODE_BIT_CLEAR)) begin
      next_state.mode = state.mode & ~req_i.wdata;
    end

    // No equality check; host keeps these apart
    if (is_write(req_i, `TTC_OFS_TEST_WRITE_ADDRESS)) begin
      next_state.waddr = req_i.wdata[10:0];
    end
    if (is_write(req_i, `TTC_OFS_TEST_READ_ADDRESS)) begin
      next_state.raddr = req_i.wdata[10:0];
    end

    // Upper half waits for the lower write
    if (is_write(req_i, `TTC_OFS_TEST_PATTERN_UPPER)) begin
      next_state.upper = req_i.wdata;
    end

    // Lower half commits the word; ignored outside memory test mode
    if (is_write(req_i, `TTC_OFS_TEST_PATTERN_LOWER) && state.mode[`TTC_MODE_MEM_TEST]) begin
      next_state.mem_write.valid = 1'b1;
      next_state.mem_write.addr = state.waddr;
      next_state.mem_write.data = {state.upper, req_i.wdata};
    end

    // Also feeds the event header builder
    if (is_write(req_i, `TTC_OFS_CRATE_NUMBER)) begin
      next_state.crate = req_i.wdata;
    end

    // Every eight-bit value is taken as written
    if (is_write(req_i, `TTC_OFS_RANGE_SETTING)) begin
      next_state.range = req_i.wdata[7:0];
    end

    if (is_write(req_i, `TTC_OFS_SLIDE_FIXED_VALUE)) begin
      next_state.slide_const = req_i.wdata[7:0];
    end

    // Dummy location: written data ignored
    if (is_write(req_i, `TTC_OFS_SOFT_CONVERSION_TRIGGER)) begin
      next_state.conv = 1'b1;
    end

    // Clearing wins over a simultaneous count: the host asked for zero
    if (is_write(req_i, `TTC_OFS_EVENT_COUNT_CLEAR) || soft_reset_i) begin
      next_state.evcount = '0;
    end else if (event_count_inc_i) begin
      next_state.evcount = state.evcount + 1'b1;
    end

    // Latest results, latched on their strobes
    if (block_a_valid_i) begin
      next_state.block_a = block_a_value_i;
    end
    if (block_b_valid_i) begin
      next_state.block_b = block_b_value_i;
    end

    // Sliding scale steps while enabled, else holds the fixed constant
    next_state.slide_ramp = state.slide_ramp + 1'b1;
    if (state.mode[`TTC_MODE_SLIDE_ON]) begin
      next_state.slide_dac = state.slide_ramp;
    end else begin
      next_state.slide_dac = state.slide_const;
    end

    // Acceptance check of one converted channel value
    if (state.mode[`TTC_MODE_THRESHOLD_STEP_SELECT]) begin
      limit = {4'h0, entry[7:0], 1'b0} << `TTC_SCALE_FINE;
    end else begin
      limit = {4'h0, entry[7:0], 1'b0} << `TTC_SCALE_COARSE;
    end
    limit = limit >> 1;
    next_state.chk_valid = check_i.valid;
    // Comparing against threshold x 16 is comparing the upper eight bits
    next_state.chk_accept = !entry[`TTC_KILL_BIT] && ({1'b0, check_i.value} >= limit);

    // Register reads answer one cycle later
    if (req_i.rd) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = 16'h0000;
      if (req_i.addr >= `TTC_OFS_ROM_FIRST) begin
        next_state.rdata = {8'h00, rom_byte(req_i.addr)};
      end else if (thr_hit) begin
        next_state.rdata = {7'h00, thr_mem[thr_index]};
      end else begin
        // Write-only locations read as zero
        unique case (req_i.addr)
          `TTC_OFS_MODE_SET: next_state.rdata = state.mode;
          `TTC_OFS_CRATE_NUMBER: next_state.rdata = state.crate;
          `TTC_OFS_RANGE_SETTING: next_state.rdata = {8'h00, state.range};
          `TTC_OFS_SLIDE_FIXED_VALUE: next_state.rdata = {8'h00, state.slide_const};
          `TTC_OFS_BLOCK_A_RESULT: next_state.rdata = {4'h0, state.block_a};
          `TTC_OFS_BLOCK_B_RESULT: next_state.rdata = {4'h0, state.block_b};
          default: next_state.rdata = 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  // Soft reset returns mode and config to defaults, leaves thresholds alone
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || soft_reset_i) begin
      state <= '0;
      // Reset value overrides the cleared field
      state.mode <= `TTC_MODE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Thresholds clear only on hardware reset
  // Slots beyond the channel count ignore writes
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        thr_mem[i] <= '0;
      end
    end else if (req_i.wr && thr_hit && {1'b0, thr_index} < 6'(CHANNELS)) begin
      thr_mem[thr_index] <= req_i.wdata[8:0];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output below is a state flop
  assign rdata_o = state.rdata;
  assign rvalid_o = state.rvalid;
  assign mode_o = state.mode;
  assign mem_write_o = state.mem_write;
  assign test_read_address_o = state.raddr;
  assign crate_number_o = state.crate;
  assign event_count_o = state.evcount;
  assign range_setting_o = state.range;
  assign conversion_start_o = state.conv;
  assign slide_dac_o = state.slide_dac;
  assign check_valid_o = state.chk_valid;
  assign check_accept_o = state.chk_accept;
  // Word layout: value in bits 11:0, overflow flag in bit 12
  assign test_event_o.valid = state.pop_d;
  assign test_event_o.word = {3'b000, fifo_word[`TTC_OVERFLOW_BIT], fifo_word[`TTC_VALUE_W-1:0]};

endmodule : ttc_test_config_regs

// >>> verification/ttc_regs_props.sv
/*
  Port checker of the register bank.
  Assumes it is bound to ttc_test_config_regs.
*/
`timescale 1ns/1ps
module ttc_regs_props
  import ttc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  input wire ttc_pkg::ttc_reg_req_t req_i,
  input wire logic [11:0] block_a_value_i,
  input wire logic block_a_valid_i,
  input wire logic test_event_pop_i,
  input wire ttc_pkg::ttc_check_t check_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [15:0] mode_o,
  input wire ttc_pkg::ttc_mem_write_t mem_write_o,
  input wire logic [15:0] crate_number_o,
  input wire logic [23:0] event_count_o,
  input wire logic [7:0] range_setting_o,
  input wire logic conversion_start_o,
  input wire logic [7:0] slide_dac_o,
  input wire logic check_valid_o,
  input wire ttc_pkg::ttc_event_word_t test_event_o
);
  logic w_conv, w_clr, w_evc, w_low, w_crate, w_range, w_slide, r_a;
  logic [7:0] slide_k;
  logic [11:0] a_k;
  // ----
  // Decoded host writes and block A read
  // ----
  assign w_conv = req_i.wr && req_i.addr == 16'h1068;
  assign w_clr = req_i.wr && req_i.addr == 16'h1034;
  assign w_evc = req_i.wr && req_i.addr == 16'h1040;
  assign w_low = req_i.wr && req_i.addr == 16'h103A;
  assign w_crate = req_i.wr && req_i.addr == 16'h103C;
  assign w_range = req_i.wr && req_i.addr == 16'h1060;
  assign w_slide = req_i.wr && req_i.addr == 16'h106A;
  assign r_a = req_i.rd && req_i.addr == 16'h1070;
  // Shadow of the slide constant and block A result, cleared like the bank
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || soft_reset_i) begin
      slide_k <= 8'h00;
      a_k <= 12'h000;
    end else begin
      if (w_slide) slide_k <= req_i.wdata[7:0];
      if (block_a_valid_i) a_k <= block_a_value_i;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_conv_start;
    w_conv |=> conversion_start_o ##1 !conversion_start_o;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion pulse wrong");
  property p_conv_cause;
    conversion_start_o |-> $past(w_conv);
  endproperty
  a_conv_cause: assert property (p_conv_cause) else $error("conversion without write");
  property p_bit_clear;
    w_clr && !soft_reset_i |=> mode_o == ($past(mode_o) & ~$past(req_i.wdata));
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("mode bits not cleared");
  property p_count_clear;
    w_evc |=> event_count_o == 24'h000000;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("event count not cleared");
  property p_commit;
    w_low && mode_o[0] |=> mem_write_o.valid && mem_write_o.data[15:0] == $past(req_i.wdata);
  endproperty
  a_commit: assert property (p_commit) else $error("test word not committed");
  property p_no_commit;
    w_low && !mode_o[0] |=> !mem_write_o.valid;
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("commit outside test mode");
  property p_crate;
    w_crate |=> crate_number_o == $past(req_i.wdata);
  endproperty
  a_crate: assert property (p_crate) else $error("crate number not held");
  property p_range;
    w_range |=> range_setting_o == $past(req_i.wdata[7:0]);
  endproperty
  a_range: assert property (p_range) else $error("range value not held");
  property p_slide;
    (!mode_o[7] && !w_slide && !soft_reset_i) [*3] |-> slide_dac_o == slide_k;
  endproperty
  a_slide: assert property (p_slide) else $error("dac not at constant");
  property p_pop;
    test_event_pop_i && mode_o[6] |=> test_event_o.valid;
  endproperty
  a_pop: assert property (p_pop) else $error("test word not delivered");
  property p_block_a;
    r_a |=> rvalid_o && rdata_o[11:0] == $past(a_k);
  endproperty
  a_block_a: assert property (p_block_a) else $error("block A readback wrong");
  property p_check;
    check_i.valid |=> check_valid_o;
  endproperty
  a_check: assert property (p_check) else $error("check answer missing");
endmodule : ttc_regs_props

bind ttc_test_config_regs ttc_regs_props ttc_regs_props_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .soft_reset_i(soft_reset_i), .req_i(req_i), .block_a_value_i(block_a_value_i),
  .block_a_valid_i(block_a_valid_i), .test_event_pop_i(test_event_pop_i), .check_i(check_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .mode_o(mode_o), .mem_write_o(mem_write_o),
  .crate_number_o(crate_number_o), .event_count_o(event_count_o), .range_setting_o(range_setting_o),
  .conversion_start_o(conversion_start_o), .slide_dac_o(slide_dac_o), .check_valid_o(check_valid_o),
  .test_event_o(test_event_o));

// >>> verification/ttc_vme_host.sv
/*
  Host model issuing single register cycles.
  Assumes the bank takes a request on the rising edge it is seen.
*/
`timescale 1ns/1ps
module ttc_vme_host
  import ttc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rvalid_i,
  input wire logic [15:0] rdata_i,
  output ttc_pkg::ttc_reg_req_t req_o
);
  initial req_o = '0;
  // ----
  // Bus cycles
  // ----
  // Released lines show the inverse, so stale values never pass
  task automatic cycle(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : cycle
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    cycle(1'b1, a, d);
  endtask : wr
  // Waits a bounded time for the answer; no answer leaves unknown data
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    cycle(1'b0, a, 16'h0000);
    d = 'x;
    repeat (3) begin
      @(posedge ref_clk_i);
      if (rvalid_i === 1'b1) d = rdata_i;
    end
  endtask : rd
endmodule : ttc_vme_host

// >>> verification/ttc_test_config_regs_test.sv
/*
  Self-checking bench of the register bank.
  Assumes ttc_vme_host as bus master and the bound port checker.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module ttc_test_config_regs_test;
  import ttc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic soft_reset_i = 1'b0;
  logic ev_inc = 1'b0;
  logic vld = 1'b0;
  logic pop = 1'b0;
  logic [11:0] a_val = 12'h000;
  logic [11:0] b_val = 12'h000;
  ttc_check_t chk = '0;
  ttc_reg_req_t req;
  ttc_mem_write_t mw;
  ttc_event_word_t tev;
  logic [15:0] rdata, mode, crate, d;
  logic rvalid, conv, cv, ca;
  logic [10:0] rda;
  logic [23:0] evc;
  logic [7:0] rng, dac;
  int bad_count = 0;
  int n_tests = 0;
  int i;
  // Write address, write data, read address, expected read data
  logic [63:0] rows [16] = '{64'h103C_00A5_103C_00A5, 64'h1060_00FF_1060_00FF, 64'h1060_001E_1060_001E,
    64'h106A_0033_106A_0033, 64'h1032_0102_1032_4182, 64'h1034_0002_1032_4180, 64'h1034_0100_1032_4080,
    64'h1080_0012_1080_0012, 64'h10BE_0134_10BE_0134, 64'h10BF_00FF_10BE_0134, 64'h1050_FFFF_1050_0000,
    64'h1070_FFFF_1070_0000, 64'h8026_FFFF_8026_005A, 64'h8032_FFFF_8032_0021, 64'h8F06_FFFF_8F06_0052,
    64'h8028_FFFF_8028_0000};
  ttc_test_config_regs ttc_test_config_regs_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .soft_reset_i(soft_reset_i), .req_i(req), .event_count_inc_i(ev_inc), .block_a_value_i(a_val),
    .block_a_valid_i(vld), .block_b_value_i(b_val), .block_b_valid_i(vld), .check_i(chk),
    .test_event_pop_i(pop), .rdata_o(rdata), .rvalid_o(rvalid), .mode_o(mode), .mem_write_o(mw),
    .test_read_address_o(rda), .crate_number_o(crate), .event_count_o(evc), .range_setting_o(rng),
    .conversion_start_o(conv), .slide_dac_o(dac), .check_valid_o(cv), .check_accept_o(ca),
    .test_event_o(tev));
  ttc_vme_host ttc_vme_host_inst (.ref_clk_i(ref_clk_i), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));
  initial forever #2 ref_clk_i = ~ref_clk_i;
  // ----
  // Helpers
  // ----
  function automatic logic [15:0] tw(input int k);
    return {3'b000, k[0], 12'(12'h0A0 + k)};
  endfunction : tw
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    ttc_vme_host_inst.rd(a, d);
    `CHK("read data", e, d)
  endtask : rchk
  task automatic pulse_check(input logic [4:0] ch, input logic [11:0] v, input logic e);
    @(posedge ref_clk_i);
    chk <= '{valid: 1'b1, channel: ch, value: v, overflow: 1'b0};
    @(posedge ref_clk_i);
    chk.valid <= 1'b0;
    #1;
    `CHK("check accept", {1'b1, e}, {cv, ca})
  endtask : pulse_check
  task automatic pop_chk(input logic [15:0] e);
    @(posedge ref_clk_i);
    pop <= 1'b1;
    @(posedge ref_clk_i);
    pop <= 1'b0;
    #1;
    `CHK("test word", {1'b1, e}, tev)
  endtask : pop_chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    #1;
    `CHK("reset mode", 16'h4080, mode)
    for (i = 0; i < 16; i++) begin
      ttc_vme_host_inst.wr(rows[i][63:48], rows[i][47:32]);
      rchk(rows[i][31:16], rows[i][15:0]);
    end
    `CHK("range output", 8'h1E, rng)
    `CHK("crate output", 16'h00A5, crate)
    ttc_vme_host_inst.wr(16'h1032, 16'h0001);
    ttc_vme_host_inst.wr(16'h1064, 16'h0010);
    #1;
    `CHK("read address", 11'h010, rda)
    ttc_vme_host_inst.wr(16'h1036, 16'h07FF);
    ttc_vme_host_inst.wr(16'h1038, 16'hBEEF);
    ttc_vme_host_inst.wr(16'h103A, 16'h1234);
    #1;
    `CHK("memory word", {1'b1, 11'h7FF, 32'hBEEF1234}, mw)
    ttc_vme_host_inst.wr(16'h1034, 16'h0001);
    ttc_vme_host_inst.wr(16'h103A, 16'h5678);
    #1;
    `CHK("refused commit", 1'b0, mw.valid)
    ttc_vme_host_inst.wr(16'h1068, 16'h0000);
    #1;
    `CHK("conversion start", 1'b1, conv)
    @(posedge ref_clk_i);
    ev_inc <= 1'b1;
    #1;
    `CHK("conversion end", 1'b0, conv)
    repeat (3) @(posedge ref_clk_i);
    ev_inc <= 1'b0;
    vld <= 1'b1;
    a_val <= 12'hABC;
    b_val <= 12'h123;
    #1;
    `CHK("event count", 24'h000003, evc)
    @(posedge ref_clk_i);
    vld <= 1'b0;
    ttc_vme_host_inst.wr(16'h1040, 16'hABCD);
    #1;
    `CHK("count cleared", 24'h000000, evc)
    rchk(16'h1070, 16'h0ABC);
    rchk(16'h1072, 16'h0123);
    pulse_check(5'd0, 12'h120, 1'b1);
    pulse_check(5'd0, 12'h11F, 1'b0);
    pulse_check(5'd31, 12'hFFF, 1'b0);
    ttc_vme_host_inst.wr(16'h1032, 16'h0100);
    pulse_check(5'd0, 12'h024, 1'b1);
    pulse_check(5'd0, 12'h023, 1'b0);
    ttc_vme_host_inst.wr(16'h1034, 16'h0180);
    repeat (4) @(posedge ref_clk_i);
    #1;
    `CHK("slide dac", 8'h33, dac)
    ttc_vme_host_inst.wr(16'h1032, 16'h00C0);
    ttc_vme_host_inst.wr(16'h1034, 16'h0040);
    for (i = 0; i < 33; i++) ttc_vme_host_inst.wr(16'h103E, tw(i));
    ttc_vme_host_inst.wr(16'h1032, 16'h0040);
    for (i = 0; i < 32; i++) pop_chk(tw(i == 0 ? 32 : i));
    ttc_vme_host_inst.wr(16'h1034, 16'h0040);
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b0;
    rchk(16'h103C, 16'h0000);
    rchk(16'h1080, 16'h0012);
    reset_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rchk(16'h1080, 16'h0000);
    final_report();
  end
endmodule : ttc_test_config_regs_test
